/* File: include/bcto_pkg.sv */
// Purpose: Shared constants for the bridge control upper half and its discard timers.
// Assumes: Register bit k sits at configuration dword bit 16+k.
// Notes:
// How it works
// - Abort mode set: master abort becomes target abort
// - Abort mode set: posted abort raises SERR when SERR enable set
// - Abort mode clear: TRDY, all ones, no SERR
// - Reset bit zero: secondary reset stays released
// - Reset bit one: secondary side held reset
// - Secondary reset spares primary side, registers
// - Fast back-to-back only while enable set
// - Primary timer: 2^15 or 2^10 clocks
// - Secondary timer: same lengths, own select
// - Timer starts when completion reaches head
// - No repeat before expiry: drop transaction
// - Expiry sets status; write one clears
// - Expiry raises SERR when both enables set
// - Top four bits read as zero
package bcto_pkg;
	localparam int        REG_W       = 16;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Field positions within the 16-bit upper half
	localparam int        F_MAM       = 5;
	localparam int        F_SRST      = 6;
	localparam int        F_FBB       = 7;
	localparam int        F_PSEL      = 8;
	localparam int        F_SSEL      = 9;
	localparam int        F_TSTAT     = 10;
	localparam int        F_TSERR     = 11;
	localparam int        F_RSVD_LO   = 12;
	localparam int        F_RSVD_HI   = 15;
	localparam int        BYTE_LO     = 0;
	localparam int        BYTE_HI     = 1;
	localparam int        N_TIMERS    = 2;
	localparam int        T_PRI       = 0;
	localparam int        T_SEC       = 1;
	// Discard intervals in PCI clocks
	localparam int        LONG_CYCLES  = 32768;
	localparam int        SHORT_CYCLES = 1024;
	localparam int        CNT_W        = 16;
	localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
endpackage

/* File: hdl/bcto_discard_timer.sv */
// Purpose: One delayed-transaction discard timer.
// Assumes: One completion at the head at a time; start ignored while running.
// Notes: Interval chosen by select at start, so a later change waits for the next one.
`timescale 1ns/1ps
`default_nettype none
module bcto_discard_timer #(
	parameter int LONG_CYCLES  = bcto_pkg::LONG_CYCLES,
	parameter int SHORT_CYCLES = bcto_pkg::SHORT_CYCLES
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Control
	input  wire logic i_sel_short,
	input  wire logic i_clear,
	// Queue events
	input  wire logic i_head,
	input  wire logic i_repeat,
	// Result
	output logic      o_running,
	output logic      o_discard
);
	typedef struct packed {
		logic                         run;
		logic                         short_sel;
		logic [bcto_pkg::CNT_W-1:0]   cnt;
		logic                         disc;
	} bcto_tmr_t;

	localparam int                         CW         = bcto_pkg::CNT_W;
	localparam logic [bcto_pkg::CNT_W-1:0] LONG_LAST  = CW'(LONG_CYCLES - 1);
	localparam logic [bcto_pkg::CNT_W-1:0] SHORT_LAST = CW'(SHORT_CYCLES - 1);

	bcto_tmr_t st;
	bcto_tmr_t next_st;
	logic [bcto_pkg::CNT_W-1:0] last;

	always_comb begin
		next_st = st;
		next_st.disc = 1'b0;
		last = st.short_sel ? SHORT_LAST : LONG_LAST;
		if (i_clear) begin
			next_st.run = 1'b0;
			next_st.cnt = '0;
		end else if (st.run) begin
			if (i_repeat) begin
				next_st.run = 1'b0;
				next_st.cnt = '0;
			end else if (st.cnt == last) begin
				next_st.run = 1'b0;
				next_st.disc = 1'b1;
				next_st.cnt = '0;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end else if (i_head) begin
			next_st.run = 1'b1;
			next_st.short_sel = i_sel_short;
			next_st.cnt = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_running = st.run;
	assign o_discard = st.disc;

	AST_DISC_AT_LAST: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_discard) |-> $past(st.cnt) == $past(last))
		else $error("discard not at end of interval");
endmodule // bcto_discard_timer
`default_nettype wire

/* File: hdl/bcto_abort_resp.sv */
// Purpose: Answer to the initiator after a forwarded transaction ended in master abort.
// Assumes: Event inputs are one-cycle pulses from the forwarding logic.
// Notes: Answer is registered, one cycle after the event.
`timescale 1ns/1ps
`default_nettype none
module bcto_abort_resp (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Mode
	input  wire logic        i_mam,
	// Abort events
	input  wire logic        i_dly_mabort,
	input  wire logic        i_dly_read,
	input  wire logic        i_post_mabort,
	// Answer
	output logic             o_rsp_valid,
	output logic             o_rsp_tabort,
	output logic             o_rsp_trdy,
	output logic [31:0]      o_rsp_rdata,
	output logic             o_post_serr
);
	typedef struct packed {
		logic        valid;
		logic        tabort;
		logic        trdy;
		logic [31:0] rdata;
		logic        pserr;
	} bcto_rsp_t;

	bcto_rsp_t st;
	bcto_rsp_t next_st;

	always_comb begin
		next_st = '0;
		if (i_dly_mabort) begin
			next_st.valid = 1'b1;
			next_st.tabort = i_mam;
			next_st.trdy = !i_mam;
			next_st.rdata = (!i_mam && i_dly_read) ? bcto_pkg::ALL_ONES : bcto_pkg::ZERO_WORD;
		end
		next_st.pserr = i_post_mabort && i_mam;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rsp_valid = st.valid;
	assign o_rsp_tabort = st.tabort;
	assign o_rsp_trdy = st.trdy;
	assign o_rsp_rdata = st.rdata;
	assign o_post_serr = st.pserr;

	AST_TABORT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_dly_mabort && i_mam |=> o_rsp_valid && o_rsp_tabort && !o_rsp_trdy)
		else $error("no target abort in abort mode");
	AST_ONES: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_dly_mabort && !i_mam && i_dly_read |=> o_rsp_trdy && o_rsp_rdata == bcto_pkg::ALL_ONES)
		else $error("read not completed with all ones");
endmodule // bcto_abort_resp
`default_nettype wire

/* File: hdl/bcto_bridge_control.sv */
// Purpose: Upper half of the bridge control register with discard timers and error paths.
// Assumes: i_clk is the PCI clock; config writes arrive one cycle each.
// Notes: Bits 4:0 belong to the lower control logic and read as zero here.
`timescale 1ns/1ps
`default_nettype none
module bcto_bridge_control #(
	parameter int LONG_CYCLES  = bcto_pkg::LONG_CYCLES,
	parameter int SHORT_CYCLES = bcto_pkg::SHORT_CYCLES
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Configuration access, upper half of the dword
	input  wire logic        i_cfg_wr,
	input  wire logic [1:0]  i_cfg_be_n,
	input  wire logic [15:0] i_cfg_wdata,
	output logic      [15:0] o_cfg_rdata,
	// Command register SERR enable
	input  wire logic        i_serr_en,
	// Delayed transaction queues, index 0 primary, 1 secondary
	input  wire logic [1:0]  i_head,
	input  wire logic [1:0]  i_repeat,
	output logic      [1:0]  o_timer_run,
	output logic      [1:0]  o_discard,
	// Forwarded transaction outcome
	input  wire logic        i_dly_mabort,
	input  wire logic        i_dly_read,
	input  wire logic        i_post_mabort,
	output logic             o_rsp_valid,
	output logic             o_rsp_tabort,
	output logic             o_rsp_trdy,
	output logic      [31:0] o_rsp_rdata,
	// Secondary side
	input  wire logic        i_sec_fbb_req,
	output logic             o_sec_fbb_go,
	output logic             o_sec_fbb_en,
	output logic             o_sec_rst_n,
	output logic             o_sec_logic_rst,
	// Primary system error
	output logic             o_pri_serr_n
);
	typedef struct packed {
		logic mam;
		logic srst;
		logic fbb;
		logic psel;
		logic ssel;
		logic tstat;
		logic tserr;
		logic serr_n;
	} bcto_state_t;

	bcto_state_t st;
	bcto_state_t next_st;

	logic        wr_lo;
	logic        wr_hi;
	logic        disc_any;
	logic        post_serr;
	logic [1:0]  sel_short;

	// Byte lane enable from active-low byte enable
	function automatic logic lane_wr(input logic wr, input logic be_n);
		return wr && !be_n;
	endfunction

	assign wr_lo = lane_wr(i_cfg_wr, i_cfg_be_n[bcto_pkg::BYTE_LO]);
	assign wr_hi = lane_wr(i_cfg_wr, i_cfg_be_n[bcto_pkg::BYTE_HI]);
	assign disc_any = |o_discard;
	assign sel_short[bcto_pkg::T_PRI] = st.psel;
	assign sel_short[bcto_pkg::T_SEC] = st.ssel;

	// Secondary reset clears the buffers, so pending completions go too
	genvar gi;
	generate
		for (gi = 0; gi < bcto_pkg::N_TIMERS; gi++) begin : g_tmr
			bcto_discard_timer #(
				.LONG_CYCLES  (LONG_CYCLES),
				.SHORT_CYCLES (SHORT_CYCLES)
			) u_tmr (
				.i_clk       (i_clk),
				.i_nrst      (i_nrst),
				.i_sel_short (sel_short[gi]),
				.i_clear     (next_st.srst),
				.i_head      (i_head[gi]),
				.i_repeat    (i_repeat[gi]),
				.o_running   (o_timer_run[gi]),
				.o_discard   (o_discard[gi])
			);
		end
	endgenerate

	bcto_abort_resp u_rsp (
		.i_clk         (i_clk),
		.i_nrst        (i_nrst),
		.i_mam         (st.mam),
		.i_dly_mabort  (i_dly_mabort),
		.i_dly_read    (i_dly_read),
		.i_post_mabort (i_post_mabort),
		.o_rsp_valid   (o_rsp_valid),
		.o_rsp_tabort  (o_rsp_tabort),
		.o_rsp_trdy    (o_rsp_trdy),
		.o_rsp_rdata   (o_rsp_rdata),
		.o_post_serr   (post_serr)
	);

	always_comb begin
		next_st = st;
		if (wr_lo) begin
			next_st.mam = i_cfg_wdata[bcto_pkg::F_MAM];
			next_st.srst = i_cfg_wdata[bcto_pkg::F_SRST];
			next_st.fbb = i_cfg_wdata[bcto_pkg::F_FBB];
		end
		if (wr_hi) begin
			next_st.psel = i_cfg_wdata[bcto_pkg::F_PSEL];
			next_st.ssel = i_cfg_wdata[bcto_pkg::F_SSEL];
			next_st.tserr = i_cfg_wdata[bcto_pkg::F_TSERR];
			// Only a one clears; zero leaves it
			if (i_cfg_wdata[bcto_pkg::F_TSTAT]) begin
				next_st.tstat = 1'b0;
			end
		end
		// Set wins over a clear in the same cycle
		if (disc_any) begin
			next_st.tstat = 1'b1;
		end
		next_st.serr_n = !(i_serr_en && ((disc_any && st.tserr) || post_serr));
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '{serr_n: 1'b1, default: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		o_cfg_rdata = bcto_pkg::REG_RESET;
		o_cfg_rdata[bcto_pkg::F_MAM] = st.mam;
		o_cfg_rdata[bcto_pkg::F_SRST] = st.srst;
		o_cfg_rdata[bcto_pkg::F_FBB] = st.fbb;
		o_cfg_rdata[bcto_pkg::F_PSEL] = st.psel;
		o_cfg_rdata[bcto_pkg::F_SSEL] = st.ssel;
		o_cfg_rdata[bcto_pkg::F_TSTAT] = st.tstat;
		o_cfg_rdata[bcto_pkg::F_TSERR] = st.tserr;
		o_cfg_rdata[bcto_pkg::F_RSVD_HI:bcto_pkg::F_RSVD_LO] = '0;
	end

	assign o_sec_rst_n = !st.srst;
	// Only the secondary side is held; primary and registers keep running
	assign o_sec_logic_rst = st.srst;
	assign o_sec_fbb_en = st.fbb;
	assign o_sec_fbb_go = i_sec_fbb_req && st.fbb && !st.srst;
	assign o_pri_serr_n = st.serr_n;

	sequence seq_discard_serr;
		disc_any && st.tserr && i_serr_en;
	endsequence

	sequence seq_serr_low;
		!o_pri_serr_n;
	endsequence

	sequence seq_status_w0;
		wr_hi && !i_cfg_wdata[bcto_pkg::F_TSTAT] && st.tstat;
	endsequence

	AST_SRST_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!st.srst |-> o_sec_rst_n && !o_sec_logic_rst)
		else $error("secondary reset asserted while bit clear");
	AST_SRST_ON: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_lo && i_cfg_wdata[bcto_pkg::F_SRST] |=> !o_sec_rst_n && o_sec_logic_rst && o_timer_run == 2'b00)
		else $error("secondary reset not applied");
	AST_CFG_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st.srst && !i_cfg_wr |=> $stable(o_cfg_rdata[bcto_pkg::F_TSERR:bcto_pkg::F_PSEL]) && st.mam == $past(st.mam))
		else $error("configuration changed under secondary reset");
	AST_FBB: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_sec_fbb_go |-> o_cfg_rdata[bcto_pkg::F_FBB])
		else $error("fast back-to-back without enable");
	AST_STAT_SET: assert property (@(posedge i_clk) disable iff (!i_nrst)
		disc_any |=> o_cfg_rdata[bcto_pkg::F_TSTAT])
		else $error("status not set on discard");
	AST_STAT_W0: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_status_w0 |=> o_cfg_rdata[bcto_pkg::F_TSTAT])
		else $error("writing zero cleared status");
	AST_SERR_DISC: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_discard_serr |=> seq_serr_low)
		else $error("no system error on discard");
	AST_SERR_CAUSE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_serr_low |-> $past(i_serr_en) && ($past(disc_any && st.tserr) || $past(post_serr)))
		else $error("system error without cause");
	AST_POST_SERR: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_post_mabort && st.mam && i_serr_en ##1 i_serr_en |=> seq_serr_low)
		else $error("posted abort did not raise system error");
	AST_RSVD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_cfg_rdata[bcto_pkg::F_RSVD_HI:bcto_pkg::F_RSVD_LO] == '0 && o_cfg_rdata[bcto_pkg::F_MAM-1:0] == '0)
		else $error("reserved bits nonzero");

	// Posted abort in normal mode with no discard behind it
	sequence seq_post_quiet;
		i_post_mabort && !st.mam ##1 !disc_any;
	endsequence

	sequence seq_status_w1;
		wr_hi && i_cfg_wdata[bcto_pkg::F_TSTAT] && !disc_any;
	endsequence

	sequence seq_disc_unreported;
		disc_any && !(st.tserr && i_serr_en) && !post_serr;
	endsequence

	AST_NO_PSERR: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_post_quiet |=> o_pri_serr_n)
		else $error("system error on posted abort in normal mode");
	AST_STAT_CLR: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_status_w1 |=> !o_cfg_rdata[bcto_pkg::F_TSTAT])
		else $error("writing one did not clear status");
	AST_DISC_QUIET: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seq_disc_unreported |=> o_pri_serr_n)
		else $error("system error on discard while reporting is off");
	AST_FBB_GO: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_sec_fbb_req && st.fbb && !st.srst |-> o_sec_fbb_go)
		else $error("fast back-to-back withheld while enabled");
	AST_FBB_SRST: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st.srst |-> !o_sec_fbb_go)
		else $error("fast back-to-back during secondary reset");

	// Clear is taken at the write edge, so a held reset never shows a live timer
	generate
		for (gi = 0; gi < bcto_pkg::N_TIMERS; gi++) begin : g_ast
			AST_TMR_START: assert property (@(posedge i_clk) disable iff (!i_nrst)
				i_head[gi] && !o_timer_run[gi] && !next_st.srst |=> o_timer_run[gi])
				else $error("timer did not start at head");
			AST_TMR_STOP: assert property (@(posedge i_clk) disable iff (!i_nrst)
				i_repeat[gi] && o_timer_run[gi] |=> !o_timer_run[gi] && !o_discard[gi])
				else $error("timer not stopped by repeat");
			AST_TMR_HELD: assert property (@(posedge i_clk) disable iff (!i_nrst)
				st.srst |-> !o_timer_run[gi] && !o_discard[gi])
				else $error("timer active during secondary reset");
		end
	endgenerate
endmodule // bcto_bridge_control
`default_nettype wire

/* File: test/bcto_initiator_model.sv */
// Purpose: Initiators that repeat delayed requests on the primary and secondary bus.
// Assumes: A lag of zero means the initiator never comes back.
// Notes: Head and repeat leave as one-cycle pulses, repeat lag cycles after head.
`timescale 1ns/1ps
`default_nettype none
module bcto_initiator_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Commands from the bench
	input  wire logic [1:0]  i_issue,
	input  wire logic [15:0] i_lag,
	// Queue events
	output logic      [1:0]  o_head,
	output logic      [1:0]  o_repeat
);
	int wait_cnt [2];
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_head <= '0;
			o_repeat <= '0;
			wait_cnt <= '{0, 0};
		end else begin
			for (int k = 0; k < 2; k++) begin
				o_head[k] <= i_issue[k];
				o_repeat[k] <= (wait_cnt[k] == 1);
				if (i_issue[k])
					wait_cnt[k] <= int'(i_lag);
				else if (wait_cnt[k] > 0)
					wait_cnt[k] <= wait_cnt[k] - 1;
			end
		end
	end
endmodule // bcto_initiator_model
`default_nettype wire

/* File: test/test_bridge_control_timeouts.sv */
// Purpose: Self-checking bench for the bridge control upper half.
// Assumes: Short intervals stand in for the long ones to keep the run brief.
// Notes: Register model is an int updated on every write.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_control_timeouts;
	localparam int LONG  = 64;
	localparam int SHORT = 8;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wr = 1'b0;
	logic [1:0]  be_n = 2'b11;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        serr_en = 1'b0;
	logic [1:0]  issue = 2'b00;
	logic [15:0] lag = 16'h0000;
	logic [1:0]  head, rep, run, disc;
	logic        mab = 1'b0, rd = 1'b0, pmab = 1'b0, fbb_req = 1'b0;
	logic        r_valid, r_tab, r_trdy, fbb_go, fbb_en, srst_n, slog_rst, serr_n;
	logic [31:0] r_data;
	logic [31:0] seed = 32'he5d1_7414;
	int          m_reg = 0;
	int          n_mismatch = 0;
	int          check_count = 0;

	always #25 clk = ~clk;

	bcto_initiator_model u_init (.i_clk(clk), .i_nrst(nrst), .i_issue(issue), .i_lag(lag),
		.o_head(head), .o_repeat(rep));
	bcto_bridge_control #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) DUT (
		.i_clk(clk), .i_nrst(nrst), .i_cfg_wr(wr), .i_cfg_be_n(be_n), .i_cfg_wdata(wdata),
		.o_cfg_rdata(rdata), .i_serr_en(serr_en), .i_head(head), .i_repeat(rep),
		.o_timer_run(run), .o_discard(disc), .i_dly_mabort(mab), .i_dly_read(rd),
		.i_post_mabort(pmab), .o_rsp_valid(r_valid), .o_rsp_tabort(r_tab), .o_rsp_trdy(r_trdy),
		.o_rsp_rdata(r_data), .i_sec_fbb_req(fbb_req), .o_sec_fbb_go(fbb_go),
		.o_sec_fbb_en(fbb_en), .o_sec_rst_n(srst_n), .o_sec_logic_rst(slog_rst),
		.o_pri_serr_n(serr_n));

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// Writable bits only; status is write-one-to-clear on the upper lane
	task automatic write(logic [1:0] b, logic [15:0] d);
		int m;
		m = (b[0] ? 0 : 32'h0000_00FF) | (b[1] ? 0 : 32'h0000_FF00);
		tick();
		wr = 1'b1;
		be_n = b;
		wdata = d;
		tick();
		wr = 1'b0;
		m_reg = (m_reg & ~(m & 32'h0000_0BE0)) | (int'(d) & m & 32'h0000_0BE0);
		if (d[10] && !b[1])
			m_reg = m_reg & ~32'h0000_0400;
		check("cfg_rdata", rdata, m_reg[15:0]);
		check("sec_rst_n", srst_n, !m_reg[6]);
		check("sec_logic_rst", slog_rst, m_reg[6]);
		check("fbb_en", fbb_en, m_reg[7]);
		check("fbb_go", fbb_go, fbb_req && m_reg[7] && !m_reg[6]);
	endtask

	// Lag zero: expect discard exactly L cycles after the head edge
	task automatic run_timer(int k, int lg);
		int n;
		int len;
		len = m_reg[8 + k] ? SHORT : LONG;
		issue[k] = 1'b1;
		lag = lg[15:0];
		n = 0;
		while (n < len + 8 && disc[k] !== 1'b1) begin
			tick();
			n++;
			if (n == 1)
				issue = 2'b00;
			if (n == 2)
				check("timer_run", run[k], 1'b1);
		end
		if (lg == 0) begin
			check("discard_at", n, len + 2);
			if (n >= len + 8)
				finish_test();
			m_reg = m_reg | 32'h0000_0400;
			tick();
			check("serr_n", serr_n, !(serr_en && m_reg[11]));
			check("status", rdata, m_reg[15:0]);
		end else begin
			check("no_discard", disc[k], 1'b0);
			check("run_stop", run[k], 1'b0);
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		check("rst_rdata", rdata, 16'h0000);
		check("rst_sec_n", srst_n, 1'b1);
		check("rst_serr_n", serr_n, 1'b1);
		#1;
		nrst = 1'b1;
		write(2'b00, 16'hFFFF);
		write(2'b01, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			seed = xorshift(seed);
			fbb_req = seed[20];
			write(seed[17:16], seed[15:0]);
		end
		for (int k = 0; k < 2; k++) begin
			for (int s = 0; s < 2; s++) begin
				serr_en = s[0];
				write(2'b00, 16'h0800 | (s[0] << (8 + k)));
				run_timer(k, 0);
				write(2'b00, m_reg[15:0] & 16'hFBFF);
				write(2'b01, 16'h0400);
			end
		end
		run_timer(0, 3);
		write(2'b00, 16'h0A00);
		run_timer(1, SHORT);
		issue = 2'b01;
		tick();
		issue = 2'b00;
		repeat (3) tick();
		write(2'b10, 16'h0040);
		check("run_in_srst", run, 2'b00);
		write(2'b10, 16'h0000);
		serr_en = 1'b0;
		for (int mam = 0; mam < 2; mam++) begin
			write(2'b10, mam ? 16'h0020 : 16'h0000);
			for (int r = 0; r < 2; r++) begin
				tick();
				mab = 1'b1;
				rd = r[0];
				tick();
				mab = 1'b0;
				check("rsp_valid", r_valid, 1'b1);
				check("rsp_tabort", r_tab, mam[0]);
				check("rsp_trdy", r_trdy, !mam[0]);
				check("rsp_rdata", r_data, (!mam && r) ? 32'hFFFF_FFFF : 32'h0000_0000);
			end
			for (int se = 0; se < 2; se++) begin
				tick();
				serr_en = se[0];
				pmab = 1'b1;
				tick();
				pmab = 1'b0;
				tick();
				check("post_serr_n", serr_n, !(mam && se));
			end
		end
		finish_test();
	end
endmodule // test_bridge_control_timeouts
`default_nettype wire
